// File: logic/dbf_pkg.sv
`default_nettype none
package dbf_pkg;

  // ---------------------------------------------------------------
  // Register map and field layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_FMT = 4'h2;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // Decimation codes and the complex decimation factor behind each.
  localparam int DEC_W = 4;
  localparam logic [3:0] DEC_CODE_MAX = 4'h8;
  localparam logic [3:0] DEC_CODE_FIRST_WIDE_ONLY = 4'h7;
  localparam logic [8:0][5:0] DEC_TAB = {6'h20, 6'h18, 6'h14, 6'h12, 6'h10,
                                         6'h0C, 6'h0A, 6'h09, 6'h08};

  // Link format selection: 8 lanes F=2, or 4 lanes F=4.
  localparam logic FMT_L8 = 1'b0;
  localparam logic FMT_L4 = 1'b1;
  localparam logic [3:0] L_L8 = 4'h8;
  localparam logic [3:0] L_L4 = 4'h4;
  localparam logic [3:0] M_ALL = 4'h8;
  localparam logic [2:0] F_L8 = 3'h2;
  localparam logic [2:0] F_L4 = 3'h4;
  localparam logic [1:0] S_ALL = 2'h1;
  localparam logic [5:0] PLL_L8 = 6'h14;
  localparam logic [5:0] PLL_L4 = 6'h28;
  localparam logic [1:0] SEL0_L8 = 2'h1;
  localparam logic [1:0] SEL0_L4 = 2'h2;
  localparam logic [1:0] SEL1_ALL = 2'h0;
  localparam logic [1:0] SEL2_ALL = 2'h0;

  // Octet position within a frame.
  localparam logic [1:0] OCT_FIRST = 2'h0;
  localparam logic [1:0] OCT_LAST_L8 = 2'h1;
  localparam logic [1:0] OCT_LAST_L4 = 2'h3;
  localparam logic [1:0] OCT_STEP = 2'h1;
  localparam logic [7:0] OCT_IDLE = 8'h00;

  localparam int LANES_PER_CH = 4;
  localparam int NUM_CH = 2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] b1_i;
    logic [15:0] b1_q;
    logic [15:0] b2_i;
    logic [15:0] b2_q;
  } dbf_chan_smp_t;

  typedef struct packed {
    logic [22:0] rsvd;
    logic [3:0] dec;
    logic fmt;
    logic [1:0] rsvd_lo;
    logic enable;
  } dbf_ctrl_reg_t;

  typedef struct packed {
    logic [26:0] rsvd;
    logic [5:0] unused_pad;
  } dbf_pad_t;

  typedef struct packed {
    logic rsvd;
    logic [5:0] dec_factor;
    logic [1:0] sel2;
    logic [1:0] sel1;
    logic [1:0] sel0;
    logic [5:0] pll_mult;
    logic [1:0] s;
    logic [2:0] f;
    logic [3:0] m;
    logic [3:0] l;
  } dbf_fmt_reg_t;

  typedef enum logic {ST_IDLE, ST_SEND} dbf_state_t;

endpackage : dbf_pkg
`default_nettype wire

// File: logic/dbf_chan_map.sv
`timescale 1ns/100ps
`default_nettype none
module dbf_chan_map (
  input wire dbf_pkg::dbf_chan_smp_t i_smp,
  input wire logic [1:0] i_oct,
  input wire logic i_fmt,
  output logic [3:0][7:0] o_lane
);

  wire [15:0] wide_smp [4];
  wire [15:0] narrow_b1;
  wire [15:0] narrow_b2;
  wire [15:0] byte_src_sel;

  assign wide_smp[0] = i_smp.b1_i;  // R05
  assign wide_smp[1] = i_smp.b1_q;  // R05
  assign wide_smp[2] = i_smp.b2_i;  // R05
  assign wide_smp[3] = i_smp.b2_q;  // R05
  assign narrow_b1 = i_oct[1] ? i_smp.b1_q : i_smp.b1_i;  // R06
  assign narrow_b2 = i_oct[1] ? i_smp.b2_q : i_smp.b2_i;  // R06

  genvar g;
  generate
    for (g = 0; g < dbf_pkg::LANES_PER_CH; g++) begin : g_lane
      wire [15:0] src;
      wire active;
      assign active = (i_fmt == dbf_pkg::FMT_L8) || (g == 1) || (g == 2);  // R06
      assign src = (i_fmt == dbf_pkg::FMT_L8) ? wide_smp[g] : ((g == 1) ? narrow_b1 : narrow_b2);
      assign o_lane[g] = !active ? dbf_pkg::OCT_IDLE : (i_oct[0] ? src[7:0] : src[15:8]);  // R05
    end
  endgenerate

endmodule : dbf_chan_map
`default_nettype wire

// File: logic/dbf_framer.sv
// Notes on behaviour
// R01: Two downconverters per channel, nine allowed decimations.
// R02: Eight lanes: LMFS 8821, PLL 20X, selects 1,0,0.
// R03: Four lanes: LMFS 4841, PLL 40X, selects 2,0,0.
// R04: Decimation 24 and 32 allow four lanes only.
// R05: Eight lanes: one sample per lane, upper octet first.
// R06: Four lanes: lanes 1,2 carry I then Q.
// R07: First lane group channel A, second channel B.
// R08: Receiver uses matching LMFS and octet mapping.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module dbf_framer (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  input wire dbf_pkg::dbf_chan_smp_t i_smp_a,
  input wire dbf_pkg::dbf_chan_smp_t i_smp_b,
  input wire logic i_smp_valid,
  output logic o_smp_ready,
  output logic o_lane_valid,
  output logic o_frame_start,
  output logic [7:0] o_chan_a_lane0,
  output logic [7:0] o_chan_a_lane1,
  output logic [7:0] o_chan_a_lane2,
  output logic [7:0] o_chan_a_lane3,
  output logic [7:0] o_chan_b_lane0,
  output logic [7:0] o_chan_b_lane1,
  output logic [7:0] o_chan_b_lane2,
  output logic [7:0] o_chan_b_lane3,
  output logic [1:0] o_link_format_sel0,
  output logic [1:0] o_link_format_sel1,
  output logic [1:0] o_link_format_sel2,
  output logic [5:0] o_pll_mult
);

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  dbf_pkg::dbf_ctrl_reg_t ctrl_ff;
  logic reject_ff;
  logic [31:0] rd_data_ff;
  dbf_pkg::dbf_ctrl_reg_t wr_ctrl;
  dbf_pkg::dbf_fmt_reg_t fmt_view;
  wire wr_ctrl_hit;
  wire wr_stat_hit;
  wire dec_ok;
  wire wr_ok;
  wire cfg_run;
  wire busy;
  wire [31:0] nxt_rd_data;

  assign wr_ctrl = dbf_pkg::dbf_ctrl_reg_t'(i_wr_data[30:0]);
  assign wr_ctrl_hit = i_wr && (i_addr == dbf_pkg::ADDR_CTRL);
  assign wr_stat_hit = i_wr && (i_addr == dbf_pkg::ADDR_STAT);
  assign dec_ok = (wr_ctrl.dec <= dbf_pkg::DEC_CODE_MAX);  // R01
  assign wr_ok = dec_ok && !((wr_ctrl.fmt == dbf_pkg::FMT_L8) &&
                 (wr_ctrl.dec >= dbf_pkg::DEC_CODE_FIRST_WIDE_ONLY));  // R04
  assign cfg_run = ctrl_ff.enable;

  assign fmt_view.rsvd = '0;
  assign fmt_view.dec_factor = dbf_pkg::DEC_TAB[ctrl_ff.dec];
  assign fmt_view.sel2 = dbf_pkg::SEL2_ALL;
  assign fmt_view.sel1 = dbf_pkg::SEL1_ALL;
  assign fmt_view.sel0 = ctrl_ff.fmt ? dbf_pkg::SEL0_L4 : dbf_pkg::SEL0_L8;  // R02 R03
  assign fmt_view.pll_mult = ctrl_ff.fmt ? dbf_pkg::PLL_L4 : dbf_pkg::PLL_L8;  // R02 R03
  assign fmt_view.s = dbf_pkg::S_ALL;
  assign fmt_view.f = ctrl_ff.fmt ? dbf_pkg::F_L4 : dbf_pkg::F_L8;  // R02 R03
  assign fmt_view.m = dbf_pkg::M_ALL;
  assign fmt_view.l = ctrl_ff.fmt ? dbf_pkg::L_L4 : dbf_pkg::L_L8;  // R02 R03

  assign nxt_rd_data = !i_rd ? dbf_pkg::RD_UNMAPPED :
                       (i_addr == dbf_pkg::ADDR_CTRL) ? 32'(ctrl_ff) :
                       (i_addr == dbf_pkg::ADDR_STAT) ? {30'h0000_0000, reject_ff, busy} :
                       (i_addr == dbf_pkg::ADDR_FMT) ? 32'(fmt_view) : dbf_pkg::RD_UNMAPPED;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_ff <= '0;
      reject_ff <= 1'b0;
      rd_data_ff <= 32'h0000_0000;
    end else if (i_ce) begin
      rd_data_ff <= nxt_rd_data;
      if (wr_ctrl_hit && wr_ok) begin
        ctrl_ff.enable <= wr_ctrl.enable;
        ctrl_ff.fmt <= wr_ctrl.fmt;
        ctrl_ff.dec <= wr_ctrl.dec;
      end
      if (wr_ctrl_hit && !wr_ok) begin
        reject_ff <= 1'b1;  // R04
      end else if (wr_stat_hit && i_wr_data[1]) begin
        reject_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencing
  // ---------------------------------------------------------------
  dbf_pkg::dbf_state_t state_ff;
  dbf_pkg::dbf_state_t nxt_state;
  logic [1:0] oct_ff;
  logic [1:0] nxt_oct;
  logic act_fmt_ff;
  logic ready_ff;
  logic valid_ff;
  logic start_ff;
  dbf_pkg::dbf_chan_smp_t hold_ff [dbf_pkg::NUM_CH];
  logic [3:0][7:0] lanes_ff [dbf_pkg::NUM_CH];
  logic [3:0][7:0] map_lanes [dbf_pkg::NUM_CH];
  wire take;
  wire nxt_fmt;
  wire [1:0] oct_last;
  wire at_last;
  wire nxt_ready;

  assign busy = (state_ff == dbf_pkg::ST_SEND);
  assign take = ready_ff && i_smp_valid && cfg_run;
  assign oct_last = act_fmt_ff ? dbf_pkg::OCT_LAST_L4 : dbf_pkg::OCT_LAST_L8;
  assign at_last = (oct_ff == oct_last);

  always_comb begin
    nxt_state = state_ff;
    nxt_oct = oct_ff;
    case (state_ff)
      dbf_pkg::ST_IDLE: begin
        if (take) begin
          nxt_state = dbf_pkg::ST_SEND;
          nxt_oct = dbf_pkg::OCT_FIRST;
        end
      end
      dbf_pkg::ST_SEND: begin
        if (!at_last) begin
          nxt_oct = oct_ff + dbf_pkg::OCT_STEP;
        end else if (take) begin
          nxt_oct = dbf_pkg::OCT_FIRST;
        end else begin
          nxt_state = dbf_pkg::ST_IDLE;
          nxt_oct = dbf_pkg::OCT_FIRST;
        end
      end
      default: begin
        nxt_state = dbf_pkg::ST_IDLE;
        nxt_oct = dbf_pkg::OCT_FIRST;
      end
    endcase
  end

  // Ready follows the format of the frame on the lanes, not a newer CTRL value.
  assign nxt_fmt = take ? ctrl_ff.fmt : act_fmt_ff;
  assign nxt_ready = cfg_run && ((nxt_state == dbf_pkg::ST_IDLE) ||
                     (nxt_oct == (nxt_fmt ? dbf_pkg::OCT_LAST_L4 : dbf_pkg::OCT_LAST_L8)));

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= dbf_pkg::ST_IDLE;
      oct_ff <= dbf_pkg::OCT_FIRST;
      act_fmt_ff <= dbf_pkg::FMT_L8;
      ready_ff <= 1'b0;
      valid_ff <= 1'b0;
      start_ff <= 1'b0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      oct_ff <= nxt_oct;
      ready_ff <= nxt_ready;
      valid_ff <= busy;
      start_ff <= busy && (oct_ff == dbf_pkg::OCT_FIRST);
      if (take) begin
        act_fmt_ff <= ctrl_ff.fmt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-channel lane mapping
  // ---------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < dbf_pkg::NUM_CH; c++) begin : g_ch
      dbf_chan_map u_map (
        .i_smp(hold_ff[c]),
        .i_oct(oct_ff),
        .i_fmt(act_fmt_ff),
        .o_lane(map_lanes[c])
      );
      always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          hold_ff[c] <= '0;
          lanes_ff[c] <= '0;
        end else if (i_ce) begin
          if (take) begin
            hold_ff[c] <= (c == 0) ? i_smp_a : i_smp_b;  // R07
          end
          lanes_ff[c] <= busy ? map_lanes[c] : '0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic [1:0] sel0_ff;
  logic [1:0] sel1_ff;
  logic [1:0] sel2_ff;
  logic [5:0] pll_ff;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel0_ff <= dbf_pkg::SEL0_L8;
      sel1_ff <= dbf_pkg::SEL1_ALL;
      sel2_ff <= dbf_pkg::SEL2_ALL;
      pll_ff <= dbf_pkg::PLL_L8;
    end else if (i_ce) begin
      sel0_ff <= fmt_view.sel0;  // R02 R03
      sel1_ff <= fmt_view.sel1;  // R02 R03
      sel2_ff <= fmt_view.sel2;  // R02 R03
      pll_ff <= fmt_view.pll_mult;  // R02 R03
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_smp_ready = ready_ff;
  assign o_lane_valid = valid_ff;
  assign o_frame_start = start_ff;
  assign o_chan_a_lane0 = lanes_ff[0][0];  // R07
  assign o_chan_a_lane1 = lanes_ff[0][1];
  assign o_chan_a_lane2 = lanes_ff[0][2];
  assign o_chan_a_lane3 = lanes_ff[0][3];
  assign o_chan_b_lane0 = lanes_ff[1][0];  // R07
  assign o_chan_b_lane1 = lanes_ff[1][1];
  assign o_chan_b_lane2 = lanes_ff[1][2];
  assign o_chan_b_lane3 = lanes_ff[1][3];
  assign o_link_format_sel0 = sel0_ff;
  assign o_link_format_sel1 = sel1_ff;
  assign o_link_format_sel2 = sel2_ff;
  assign o_pll_mult = pll_ff;

endmodule : dbf_framer
`default_nettype wire

// File: dv/dbf_framer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dbf_framer_monitor (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_wr,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire dbf_pkg::dbf_chan_smp_t i_smp_a,
  input wire dbf_pkg::dbf_chan_smp_t i_smp_b,
  input wire logic i_smp_valid,
  input wire logic o_smp_ready,
  input wire logic o_frame_start,
  input wire logic [7:0] o_chan_a_lane0,
  input wire logic [7:0] o_chan_a_lane1,
  input wire logic [7:0] o_chan_a_lane2,
  input wire logic [7:0] o_chan_a_lane3,
  input wire logic [7:0] o_chan_b_lane0,
  input wire logic [7:0] o_chan_b_lane1,
  input wire logic [7:0] o_chan_b_lane2,
  input wire logic [7:0] o_chan_b_lane3,
  input wire logic [1:0] o_link_format_sel0,
  input wire logic [1:0] o_link_format_sel1,
  input wire logic [1:0] o_link_format_sel2,
  input wire logic [5:0] o_pll_mult
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  wire take = o_smp_ready && i_smp_valid;
  wire wide = o_link_format_sel0 == 2'h1;
  wire bad_wr = i_wr && i_addr == 4'h0 && (i_wr_data[7:4] > 4'h8
                || (!i_wr_data[3] && i_wr_data[7:4] >= 4'h7));
  a_sel_pll_pair: assert property ((wide && o_pll_mult == 6'h14) ||
    (o_link_format_sel0 == 2'h2 && o_pll_mult == 6'h28)) else $error("select and pll disagree");
  a_upper_sel_zero: assert property (o_link_format_sel1 == 2'h0 &&
    o_link_format_sel2 == 2'h0) else $error("upper selects not zero");
  a_start_delay: assert property (take |-> ##2 o_frame_start)
    else $error("frame start late");
  a_start_single: assert property (o_frame_start |=> !o_frame_start)
    else $error("frame shorter than two octets");
  a_reject_keeps: assert property (bad_wr |=> ##1 $stable(o_pll_mult) &&
    $stable(o_link_format_sel0)) else $error("refused setting took effect");
  a_wide_map: assert property (take && wide |-> ##2
    (o_chan_a_lane0 == $past(i_smp_a.b1_i[15:8], 2) && o_chan_a_lane3 == $past(i_smp_a.b2_q[15:8], 2)
    && o_chan_b_lane1 == $past(i_smp_b.b1_q[15:8], 2)) ##1 (o_chan_a_lane2 ==
    $past(i_smp_a.b2_i[7:0], 3) && o_chan_b_lane0 == $past(i_smp_b.b1_i[7:0], 3)))
    else $error("wide lane octet wrong");
  a_narrow_map: assert property (take && !wide |-> ##2
    (o_chan_a_lane1 == $past(i_smp_a.b1_i[15:8], 2) && o_chan_b_lane2 == $past(i_smp_b.b2_i[15:8], 2))
    ##1 o_chan_a_lane1 == $past(i_smp_a.b1_i[7:0], 3) ##1 (o_chan_a_lane1 ==
    $past(i_smp_a.b1_q[15:8], 4) && o_chan_b_lane2 == $past(i_smp_b.b2_q[15:8], 4))
    ##1 o_chan_a_lane2 == $past(i_smp_a.b2_q[7:0], 5)) else $error("narrow lane octet wrong");
  a_narrow_idle: assert property (take && !wide |-> ##2 (o_chan_a_lane0 == 8'h00 &&
    o_chan_a_lane3 == 8'h00 && o_chan_b_lane0 == 8'h00 && o_chan_b_lane3 == 8'h00) [*4])
    else $error("unused lane not zero");
endmodule : dbf_framer_monitor
bind dbf_framer dbf_framer_monitor u_mon (.*);
`default_nettype wire

// File: dv/dbf_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module dbf_rx_model (
  input wire logic i_mclk,
  input wire logic i_fmt,
  input wire logic i_lane_valid,
  input wire logic i_frame_start,
  input wire logic [3:0][7:0] i_a,
  input wire logic [3:0][7:0] i_b,
  output logic o_done,
  output dbf_pkg::dbf_chan_smp_t o_a,
  output dbf_pkg::dbf_chan_smp_t o_b
);
  logic [3:0][31:0] sa, sb;
  logic [1:0] k;
  function automatic logic [63:0] rebuild(input logic [3:0][31:0] s, input logic f);
    return f ? {s[1], s[2]} : {s[0][15:0], s[1][15:0], s[2][15:0], s[3][15:0]};
  endfunction : rebuild
  always @(posedge i_mclk) begin
    o_done <= 1'b0;
    if (i_lane_valid) begin
      k = i_frame_start ? 2'h0 : k + 2'h1;
      for (int n = 0; n < 4; n++) begin
        sa[n] = {sa[n][23:0], i_a[n]};
        sb[n] = {sb[n][23:0], i_b[n]};
      end
      if (k == (i_fmt ? 2'h3 : 2'h1)) begin
        o_done <= 1'b1;
        o_a <= rebuild(sa, i_fmt);
        o_b <= rebuild(sb, i_fmt);
      end
    end
  end
endmodule : dbf_rx_model
`default_nettype wire

// File: dv/tb_dbf_framer.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dbf_framer;
  logic i_mclk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, i_smp_valid = 0, fmt = 0, rx_done;
  logic i_ce = 1;
  logic [3:0] i_addr = 0;
  logic [31:0] i_wr_data = 0, o_rd_data, d;
  logic o_smp_ready, o_lane_valid, o_frame_start;
  logic [7:0] o_chan_a_lane0, o_chan_a_lane1, o_chan_a_lane2, o_chan_a_lane3;
  logic [7:0] o_chan_b_lane0, o_chan_b_lane1, o_chan_b_lane2, o_chan_b_lane3;
  logic [1:0] o_link_format_sel0, o_link_format_sel1, o_link_format_sel2;
  logic [5:0] o_pll_mult;
  dbf_pkg::dbf_chan_smp_t i_smp_a = 0, i_smp_b = 0, rx_a, rx_b;
  logic [63:0] va[2] = '{64'h1122_3344_5566_7788, 64'h99AA_BBCC_DDEE_FF01};
  logic [63:0] vb[2] = '{64'h0F1E_2D3C_4B5A_6978, 64'h8796_A5B4_C3D2_E1F0};
  logic [5:0] dt[9] = '{6'h08, 6'h09, 6'h0A, 6'h0C, 6'h10, 6'h12, 6'h14, 6'h18, 6'h20};
  int errors = 0, n_tests = 0, cyc = 0;
  dbf_framer dut (.i_ce(i_ce), .*);
  dbf_rx_model rx (.i_mclk(i_mclk), .i_fmt(fmt), .i_lane_valid(o_lane_valid),
    .i_frame_start(o_frame_start), .o_done(rx_done), .o_a(rx_a), .o_b(rx_b),
    .i_a({o_chan_a_lane3, o_chan_a_lane2, o_chan_a_lane1, o_chan_a_lane0}),
    .i_b({o_chan_b_lane3, o_chan_b_lane2, o_chan_b_lane1, o_chan_b_lane0}));
  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end
  function automatic logic [31:0] fw(input logic f, input logic [5:0] dec);
    return {1'b0, dec, 4'h0, f ? 2'h2 : 2'h1, f ? 6'h28 : 6'h14, 2'h1, f ? 3'h4 : 3'h2,
            4'h8, f ? 4'h4 : 4'h8};
  endfunction : fw
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    i_wr <= 1;
    i_addr <= a;
    i_wr_data <= v;
    @(posedge i_mclk);
    i_wr <= 0;
    @(posedge i_mclk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 0;
    @(posedge i_mclk);
    d = o_rd_data;
  endtask : rd
  task automatic t_formats;
    for (int c = 0; c < 9; c++) begin
      wr(4'h0, {24'h0, c[3:0], 4'h8});
      rd(4'h2);
      `CHK(d, fw(1'b1, dt[c]))
      wr(4'h0, {24'h0, c[3:0], 4'h0});
      rd(4'h2);
      `CHK(d, fw(c > 6, dt[c]))
      rd(4'h1);
      `CHK(d[1], c > 6)
      wr(4'h1, 32'h0000_0002);
      rd(4'h1);
      `CHK(d, 32'h0000_0000)
    end
    wr(4'h0, 32'h0000_0098);
    rd(4'h2);
    `CHK(d, fw(1'b1, 6'h20))
    rd(4'h3);
    `CHK(d, 32'h0000_0000)
    $display("format test done");
  endtask : t_formats
  task automatic t_stream(input logic f);
    wr(4'h0, {28'h0, f, 3'h1});
    fmt = f;
    @(posedge i_mclk);
    `CHK(o_pll_mult, f ? 6'h28 : 6'h14)
    fork
      for (int n = 0; n < 2; n++) begin
        i_smp_a <= va[n];
        i_smp_b <= vb[n];
        i_smp_valid <= 1;
        @(posedge i_mclk);
        while (!o_smp_ready) @(posedge i_mclk);
        if (n == 1) begin
          i_smp_valid <= 0;
        end
      end
      for (int n = 0; n < 2; n++) begin
        @(posedge i_mclk);
        while (!rx_done) @(posedge i_mclk);
        `CHK({rx_a, rx_b}, {va[n], vb[n]})
      end
    join
    wr(4'h0, 32'h0000_0000);
    $display("stream test done");
  endtask : t_stream
  task automatic t_freeze;
    i_ce <= 0;
    wr(4'h0, 32'h0000_0009);
    rd(4'h2);
    `CHK(d, 32'h0000_0000)
    `CHK(o_pll_mult, 6'h14)
    i_ce <= 1;
    rd(4'h2);
    `CHK(d, fw(1'b0, 6'h08))
    $display("freeze test done");
  endtask : t_freeze
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20) @(posedge i_mclk);
    i_reset_n <= 1;
    @(posedge i_mclk);
    rd(4'h2);
    `CHK(d, fw(1'b0, 6'h08))
    $display("reset test done");
    t_formats();
    t_stream(1'b0);
    t_stream(1'b1);
    t_freeze();
    give_verdict();
  end
endmodule : tb_dbf_framer
`default_nettype wire
